// ### rtl/eau_pkg.sv
// Purpose: Shared constants and types for the effective address unit.
// Assumes: 16-bit instruction words, 32-bit registers and addresses, sixteen general registers.
// Notes:   Field positions, step sizes, masks and reset values live here only.
package eau_pkg;

   // Widths of the datapath and of the instruction fields.
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned INSTR_W = 16;
   localparam int unsigned REG_N   = 16;
   localparam int unsigned IDX_W   = 4;

   // Bit positions of the instruction fields.
   localparam int unsigned OPC_HI  = 15;
   localparam int unsigned OPC_LO  = 12;
   localparam int unsigned NFLD_HI = 11;
   localparam int unsigned NFLD_LO = 8;
   localparam int unsigned MFLD_HI = 7;
   localparam int unsigned MFLD_LO = 4;
   localparam int unsigned IMM_HI  = 7;
   localparam int unsigned D12_HI  = 11;

   // Address arithmetic constants.
   localparam logic [31:0] PC_LONG_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] STEP_BYTE    = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD    = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG    = 32'h0000_0004;

   // Values after reset.
   localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
   localparam logic [3:0]  RESET_INDEX = 4'h0;

   // Operand encoding of the instruction word, chosen by the opcode decoder upstream.
   typedef enum logic [2:0] {
      FMT_ZERO = 3'h0,
      FMT_DEST = 3'h1,
      FMT_SRC  = 3'h2,
      FMT_NM   = 3'h3,
      FMT_MAC  = 3'h4,
      FMT_NI   = 3'h5,
      FMT_NONE = 3'h6
   } eau_format_e;

   // Addressing and immediate modes.
   typedef enum logic [3:0] {
      MODE_REG_DIRECT = 4'h0,
      MODE_INDIRECT   = 4'h1,
      MODE_POST_INC   = 4'h2,
      MODE_PRE_DEC    = 4'h3,
      MODE_PC_DISP    = 4'h4,
      MODE_BRANCH8    = 4'h5,
      MODE_BRANCH12   = 4'h6,
      MODE_PC_REG     = 4'h7,
      MODE_IMM_ZERO   = 4'h8,
      MODE_IMM_SIGN   = 4'h9,
      MODE_TRAP       = 4'hA
   } eau_mode_e;

   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_WORD = 2'h1,
      SIZE_LONG = 2'h2
   } eau_size_e;

   // Which decoded register is the address base.
   typedef enum logic [1:0] {
      BASE_SRC  = 2'h0,
      BASE_DEST = 2'h1,
      BASE_SRC2 = 2'h2
   } eau_base_e;

endpackage

// ### rtl/eau_fields_if.sv
// Purpose: Carries the raw instruction word to the field decoder and the fields back.
// Assumes: Purely combinational traffic within one clock domain.
// Notes:   The dec modport belongs to the field decoder, unit to the address unit.
`timescale 1ns/1ps
`default_nettype none
interface eau_fields_if;
   import eau_pkg::*;
   logic [15:0] instrWord;
   eau_format_e format;
   logic [3:0]  opcode;
   logic [3:0]  srcIndex;
   logic [3:0]  destIndex;
   logic [3:0]  src2Index;
   logic        srcValid;
   logic        destValid;
   logic        src2Valid;
   logic [7:0]  imm8;
   logic [11:0] disp12;

   modport dec (input instrWord, format, output opcode, srcIndex, destIndex, src2Index,
                srcValid, destValid, src2Valid, imm8, disp12);
   modport unit (output instrWord, format, input opcode, srcIndex, destIndex, src2Index,
                srcValid, destValid, src2Valid, imm8, disp12);
endinterface
`default_nettype wire

// ### rtl/eau_field_decoder.sv
// Purpose: Splits an instruction word into opcode, register, immediate and displacement fields.
// Assumes: The format input is valid whenever the word is.
// Notes:   Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
`default_nettype none
module eau_field_decoder
   import eau_pkg::*;
(
   eau_fields_if.dec fb
);

   // Raw fields; the same bits mean different things depending on the format.
   wire [3:0] nField = fb.instrWord[NFLD_HI:NFLD_LO];
   wire [3:0] mField = fb.instrWord[MFLD_HI:MFLD_LO];

   // Opcode and the immediate and displacement fields are position-fixed.
   assign fb.opcode = fb.instrWord[OPC_HI:OPC_LO];
   assign fb.imm8   = fb.instrWord[IMM_HI:0];
   assign fb.disp12 = fb.instrWord[D12_HI:0];

   // Destination is bits 11..8 in the destination, two-register and immediate formats.
   assign fb.destValid = (fb.format == FMT_DEST) || (fb.format == FMT_NM) ||
                         (fb.format == FMT_NI);
   assign fb.destIndex = nField;

   // In the source format the source sits in bits 11..8, otherwise in bits 7..4.
   assign fb.srcValid = (fb.format == FMT_SRC) || (fb.format == FMT_NM) ||
                        (fb.format == FMT_MAC);
   assign fb.srcIndex = (fb.format == FMT_SRC) ? nField : mField;

   // Multiply-accumulate reads bits 11..8 as a second source, never as a destination.
   assign fb.src2Valid = (fb.format == FMT_MAC);
   assign fb.src2Index = nField;

endmodule
`default_nettype wire

// ### rtl/eau_adder.sv
// Purpose: Plain modular adder used for every address sum in the unit.
// Assumes: Both operands have the same width.
// Notes:   The carry out is dropped on purpose so sums wrap silently.
`timescale 1ns/1ps
`default_nettype none
module eau_adder #(
   parameter int unsigned WIDTH = 32
) (
   input  wire logic [WIDTH-1:0] addendA,
   input  wire logic [WIDTH-1:0] addendB,
   output logic      [WIDTH-1:0] sum
);

   // Wrap modulo two to the width; no overflow flag exists by design.
   assign sum = addendA + addendB;

endmodule
`default_nettype wire

// ### rtl/eau_address_unit.sv
// Purpose: Field decode and effective address calculation for the execution stage.
// Assumes: Mode, size, format and base select come from the opcode decoder on core_clk.
// Notes:   One instruction per clock; results appear on the edge after instrValid.
//
// Overview of operation
// - Register direct: operand is the selected register, no address is formed.
// - Register indirect: address is the register contents, register unchanged.
// - Post-increment: address is old value; register then grows by 1, 2 or 4.
// - Pre-decrement: register drops by 1, 2 or 4 first; that value is the address.
// - PC displacement: the 8-bit displacement is zero-extended, then added to PC.
// - PC displacement is scaled by one, two or four for byte, word, longword.
// - Longword PC displacement clears the two low PC bits before adding.
// - Short branch: 8-bit field sign-extended, doubled, added to PC.
// - Long branch: 12-bit field sign-extended, doubled, added to PC.
// - Register-offset branch target is PC plus the selected register.
// - Bit-test and logic immediates are zero-extended.
// - Move, add and compare-equal immediates are sign-extended to 32 bits.
// - Software trap immediate is zero-extended and times four as vector offset.
// - Word splits into opcode, registers, immediate, displacement; opcode gives meaning.
// - Destination format: bits 11..8 pick the destination register.
// - Source format: bits 11..8 pick the source register.
// - Multiply-accumulate treats the destination field as a second source.
`timescale 1ns/1ps
`default_nettype none
module eau_address_unit
   import eau_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        instrValid,
   input  wire logic [15:0] instrWord,
   input  wire eau_format_e instrFormat,
   input  wire eau_mode_e   addrMode,
   input  wire eau_size_e   accessSize,
   input  wire eau_base_e   baseSel,
   input  wire logic [31:0] pcValue,
   input  wire logic        regWrEn,
   input  wire logic [3:0]  regWrIndex,
   input  wire logic [31:0] regWrData,
   output logic             resultValid,
   output logic [3:0]       opcode,
   output logic [3:0]       srcIndex,
   output logic             srcValid,
   output logic [3:0]       destIndex,
   output logic             destValid,
   output logic [3:0]       src2Index,
   output logic             src2Valid,
   output logic             addrValid,
   output logic             targetValid,
   output logic [31:0]      effAddr,
   output logic [31:0]      operand,
   output logic [31:0]      operand2,
   output logic             updValid,
   output logic [3:0]       updIndex,
   output logic [31:0]      updValue
);

   logic        rstMeta;
   logic        rstSync;
   logic [31:0] regFile [REG_N];
   // Every check here runs on core_clk and sleeps while the synchronised reset holds.
   default clocking cbMain @(posedge core_clk); endclocking
   default disable iff (!rstSync);

   // Reset is released through two flops so every flop leaves reset on the same edge.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // Field decoding runs in its own module over the field carrier.
   eau_fields_if fieldsBus ();
   assign fieldsBus.instrWord = instrWord;
   assign fieldsBus.format    = instrFormat;

   eau_field_decoder u_decoder (
      .fb (fieldsBus)
   );

   // Base register selection and the register file read ports.
   wire [3:0]  baseIndex = (baseSel == BASE_DEST) ? fieldsBus.destIndex :
                           (baseSel == BASE_SRC2) ? fieldsBus.src2Index : fieldsBus.srcIndex;
   wire [31:0] baseValue = regFile[baseIndex];
   wire [31:0] src2Value = regFile[fieldsBus.src2Index];

   // Access size to step; an unused size code falls back to the byte step.
   wire [31:0] stepSize = (accessSize == SIZE_LONG) ? STEP_LONG :
                          (accessSize == SIZE_WORD) ? STEP_WORD : STEP_BYTE;
   wire [31:0] stepNeg  = 32'h0 - stepSize;

   // Zero-extended displacement, scaled by the access size.
   wire [31:0] dispZero = {24'h0, fieldsBus.imm8};
   wire [31:0] dispScaled = (accessSize == SIZE_LONG) ? {dispZero[29:0], 2'h0} :
                            (accessSize == SIZE_WORD) ? {dispZero[30:0], 1'h0} : dispZero;
   wire        isPcLong = (addrMode == MODE_PC_DISP) && (accessSize == SIZE_LONG);
   wire [31:0] pcBase   = isPcLong ? (pcValue & PC_LONG_MASK) : pcValue;

   // Branch displacements are sign-extended and doubled.
   wire [31:0] br8Offset  = {{23{fieldsBus.imm8[7]}}, fieldsBus.imm8, 1'h0};
   wire [31:0] br12Offset = {{19{fieldsBus.disp12[11]}}, fieldsBus.disp12, 1'h0};

   // Immediate extensions for the three immediate families.
   wire [31:0] immZero = {24'h0, fieldsBus.imm8};
   wire [31:0] immSign = {{24{fieldsBus.imm8[7]}}, fieldsBus.imm8};
   wire [31:0] immTrap = {22'h0, fieldsBus.imm8, 2'h0};

   // Operand selection for the main adder.
   wire isPcMode = (addrMode == MODE_PC_DISP) || (addrMode == MODE_BRANCH8) ||
                   (addrMode == MODE_BRANCH12) || (addrMode == MODE_PC_REG);
   wire [31:0] pcOffset = (addrMode == MODE_BRANCH8)  ? br8Offset  :
                          (addrMode == MODE_BRANCH12) ? br12Offset :
                          (addrMode == MODE_PC_REG)   ? baseValue  : dispScaled;
   wire [31:0] pcSum;
   wire [31:0] stepSum;

   // One adder forms PC-relative sums, the other the stepped register value.
   eau_adder #(.WIDTH(DATA_W)) u_pc_adder (
      .addendA (pcBase),
      .addendB (pcOffset),
      .sum     (pcSum)
   );

   eau_adder #(.WIDTH(DATA_W)) u_step_adder (
      .addendA (baseValue),
      .addendB ((addrMode == MODE_PRE_DEC) ? stepNeg : stepSize),
      .sum     (stepSum)
   );

   // Next result values. Pre-decrement uses the reduced value as address.
   wire isRegMem = (addrMode == MODE_INDIRECT) || (addrMode == MODE_POST_INC) ||
                   (addrMode == MODE_PRE_DEC);
   wire next_addrValid   = instrValid && (isRegMem || (addrMode == MODE_PC_DISP));
   wire next_targetValid = instrValid && isPcMode && (addrMode != MODE_PC_DISP);
   wire next_updValid    = instrValid && ((addrMode == MODE_POST_INC) ||
                                          (addrMode == MODE_PRE_DEC));
   wire [31:0] next_effAddr = (addrMode == MODE_PRE_DEC) ? stepSum :
                              isPcMode ? pcSum :
                              isRegMem ? baseValue : RESET_WORD;
   wire [31:0] next_operand = (addrMode == MODE_IMM_ZERO) ? immZero :
                              (addrMode == MODE_IMM_SIGN) ? immSign :
                              (addrMode == MODE_TRAP)     ? immTrap :
                              (addrMode == MODE_REG_DIRECT) ? baseValue : RESET_WORD;

   // Registered outputs; field outputs follow every word, valid or not.
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         resultValid <= 1'b0;
         opcode      <= RESET_INDEX;
         srcIndex    <= RESET_INDEX;
         srcValid    <= 1'b0;
         destIndex   <= RESET_INDEX;
         destValid   <= 1'b0;
         src2Index   <= RESET_INDEX;
         src2Valid   <= 1'b0;
         addrValid   <= 1'b0;
         targetValid <= 1'b0;
         effAddr     <= RESET_WORD;
         operand     <= RESET_WORD;
         operand2    <= RESET_WORD;
         updValid    <= 1'b0;
         updIndex    <= RESET_INDEX;
         updValue    <= RESET_WORD;
      end else begin
         resultValid <= instrValid;
         opcode      <= fieldsBus.opcode;
         srcIndex    <= fieldsBus.srcIndex;
         srcValid    <= instrValid && fieldsBus.srcValid;
         destIndex   <= fieldsBus.destIndex;
         destValid   <= instrValid && fieldsBus.destValid;
         src2Index   <= fieldsBus.src2Index;
         src2Valid   <= instrValid && fieldsBus.src2Valid;
         addrValid   <= next_addrValid;
         targetValid <= next_targetValid;
         effAddr     <= next_effAddr;
         operand     <= next_operand;
         operand2    <= fieldsBus.src2Valid ? src2Value : RESET_WORD;
         updValid    <= next_updValid;
         updIndex    <= baseIndex;
         updValue    <= stepSum;
      end
   end

   // Register file; a step write beats an outside write, since the step used the old value.
   always_ff @(posedge core_clk or negedge rstSync) begin
      if (!rstSync) begin
         for (int i = 0; i < REG_N; i++) begin
            regFile[i] <= RESET_WORD;
         end
      end else begin
         if (regWrEn) begin
            regFile[regWrIndex] <= regWrData;
         end
         if (next_updValid) begin
            regFile[baseIndex] <= stepSum;
         end
      end
   end

   // Checks on the registered results, each against the inputs one edge earlier.
   property p_reg_direct;
      (instrValid && addrMode == MODE_REG_DIRECT) |=>
         (!addrValid && !updValid && operand == $past(baseValue));
   endproperty
   a_reg_direct: assert property (p_reg_direct)
      else $error("Register direct result wrong.");

   property p_indirect;
      (instrValid && addrMode == MODE_INDIRECT && !regWrEn) |=>
         (addrValid && !updValid && effAddr == $past(baseValue)
          && regFile[$past(baseIndex)] == $past(baseValue));
   endproperty
   a_indirect: assert property (p_indirect)
      else $error("Register indirect changed the register or the address.");

   property p_post_inc;
      (instrValid && addrMode == MODE_POST_INC && accessSize == SIZE_WORD) |=>
         (effAddr == $past(baseValue) && updValue == $past(baseValue) + 32'h2
          && regFile[updIndex] == updValue);
   endproperty
   a_post_inc: assert property (p_post_inc)
      else $error("Post-increment address or update wrong.");

   property p_pre_dec;
      (instrValid && addrMode == MODE_PRE_DEC && accessSize == SIZE_LONG) |=>
         (updValid && effAddr == updValue && updValue == $past(baseValue) - 32'h4);
   endproperty
   a_pre_dec: assert property (p_pre_dec)
      else $error("Pre-decrement address or update wrong.");

   property p_pc_disp_byte;
      (instrValid && addrMode == MODE_PC_DISP && accessSize == SIZE_BYTE) |=>
         (effAddr == $past(pcValue) + {24'h0, $past(instrWord[7:0])});
   endproperty
   a_pc_disp_byte: assert property (p_pc_disp_byte)
      else $error("Byte PC displacement not zero-extended.");

   property p_pc_disp_word;
      (instrValid && addrMode == MODE_PC_DISP && accessSize == SIZE_WORD) |=>
         (effAddr == $past(pcValue) + {23'h0, $past(instrWord[7:0]), 1'h0});
   endproperty
   a_pc_disp_word: assert property (p_pc_disp_word)
      else $error("Word PC displacement not doubled.");

   property p_pc_disp_long;
      (instrValid && addrMode == MODE_PC_DISP && accessSize == SIZE_LONG) |=>
         (effAddr[1:0] == 2'h0 && effAddr[31:2] == $past(pcValue[31:2]) +
          {22'h0, $past(instrWord[7:0])});
   endproperty
   a_pc_disp_long: assert property (p_pc_disp_long)
      else $error("Longword PC displacement not masked or scaled.");

   property p_branch8;
      (instrValid && addrMode == MODE_BRANCH8) |=>
         (targetValid && effAddr == $past(pcValue) +
          {{23{$past(instrWord[7])}}, $past(instrWord[7:0]), 1'h0});
   endproperty
   a_branch8: assert property (p_branch8)
      else $error("Short branch target wrong.");

   property p_branch12;
      (instrValid && addrMode == MODE_BRANCH12) |=>
         (targetValid && effAddr == $past(pcValue) +
          {{19{$past(instrWord[11])}}, $past(instrWord[11:0]), 1'h0});
   endproperty
   a_branch12: assert property (p_branch12)
      else $error("Long branch target wrong.");

   property p_pc_reg;
      (instrValid && addrMode == MODE_PC_REG) |=>
         (targetValid && effAddr == $past(pcValue) + $past(baseValue));
   endproperty
   a_pc_reg: assert property (p_pc_reg)
      else $error("Register-offset branch target wrong.");

   property p_imm_zero;
      (instrValid && addrMode == MODE_IMM_ZERO) |=>
         (operand[31:8] == 24'h0 && operand[7:0] == $past(instrWord[7:0]));
   endproperty
   a_imm_zero: assert property (p_imm_zero)
      else $error("Logic immediate not zero-extended.");

   property p_imm_sign;
      (instrValid && addrMode == MODE_IMM_SIGN) |=>
         ($signed(operand) == $signed($past(instrWord[7:0])));
   endproperty
   a_imm_sign: assert property (p_imm_sign)
      else $error("Arithmetic immediate not sign-extended.");

   property p_trap;
      (instrValid && addrMode == MODE_TRAP) |=>
         (operand == {22'h0, $past(instrWord[7:0]), 2'h0} && !addrValid);
   endproperty
   a_trap: assert property (p_trap)
      else $error("Trap vector offset wrong.");

   property p_fields;
      instrValid |=> (resultValid && opcode == $past(instrWord[15:12]));
   endproperty
   a_fields: assert property (p_fields)
      else $error("Opcode field not passed on.");

   property p_dest_fmt;
      (instrValid && instrFormat == FMT_DEST) |=>
         (destValid && !srcValid && destIndex == $past(instrWord[11:8]));
   endproperty
   a_dest_fmt: assert property (p_dest_fmt)
      else $error("Destination format register wrong.");

   property p_src_fmt;
      (instrValid && instrFormat == FMT_SRC) |=>
         (srcValid && !destValid && srcIndex == $past(instrWord[11:8]));
   endproperty
   a_src_fmt: assert property (p_src_fmt)
      else $error("Source format register wrong.");

   property p_mac;
      (instrValid && instrFormat == FMT_MAC) |=>
         (src2Valid && !destValid && src2Index == $past(instrWord[11:8])
          && srcIndex == $past(instrWord[7:4]));
   endproperty
   a_mac: assert property (p_mac)
      else $error("Multiply-accumulate second source wrong.");

   property p_wrap;
      (instrValid && addrMode == MODE_POST_INC && accessSize == SIZE_BYTE
       && baseValue == 32'hFFFF_FFFF) |=> (updValue == 32'h0000_0000);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Post-increment did not wrap.");

endmodule
`default_nettype wire

// ### sim/test_cpu_effective_address_unit.sv
// Purpose: Self-checking bench for the effective address unit.
// Assumes: One instruction per clock; results appear one edge after it is taken.
// Notes:   A bench register mirror predicts every address and step, so steps must track.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_effective_address_unit;
   import eau_pkg::*;
   logic        core_clk, reset_n, instrValid, regWrEn;
   logic [15:0] instrWord;
   eau_format_e instrFormat;
   eau_mode_e   addrMode;
   eau_size_e   accessSize;
   eau_base_e   baseSel;
   logic [31:0] pcValue, regWrData, effAddr, operand, operand2, updValue;
   logic [3:0]  regWrIndex, opcode, srcIndex, destIndex, src2Index, updIndex;
   logic        resultValid, srcValid, destValid, src2Valid, addrValid, targetValid, updValid;
   logic [31:0] regs [16];
   logic [31:0] seed = 32'h0000_3870;
   int          num_errors = 0;
   int          tests_run = 0;
   eau_format_e fmtList [7] = '{FMT_SRC, FMT_DEST, FMT_MAC, FMT_NM, FMT_NI, FMT_ZERO, FMT_NONE};

   eau_address_unit u_eau_address_unit (.core_clk, .reset_n, .instrValid, .instrWord,
      .instrFormat, .addrMode, .accessSize, .baseSel, .pcValue, .regWrEn, .regWrIndex,
      .regWrData, .resultValid, .opcode, .srcIndex, .srcValid, .destIndex, .destValid,
      .src2Index, .src2Valid, .addrValid, .targetValid, .effAddr, .operand, .operand2,
      .updValid, .updIndex, .updValue);

   // Xorshift keeps the random run repeatable from one fixed seed.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Writes are held back to back without lowering the enable, so no signal toggles twice.
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      instrValid = 1'b0;
      regWrEn = 1'b1;
      regWrIndex = i;
      regWrData = d;
      @(posedge core_clk);
      #1;
      regs[i] = d;
      chk(resultValid, 32'h0);
   endtask

   // Drives one instruction, predicts every result from the mirror, then checks it.
   task automatic issue(input eau_mode_e m, input eau_size_e s, input eau_format_e f);
      logic [3:0]  k;
      logic [31:0] r, st, pcb, ea, op, up, o2;
      regWrEn = 1'b0;
      instrWord = 16'(rnd());
      pcValue = rnd();
      instrFormat = f;
      addrMode = m;
      accessSize = s;
      // Multiply-accumulate words sometimes take the second source as the base.
      baseSel = (f == FMT_DEST || f == FMT_NI) ? BASE_DEST :
                (f == FMT_MAC && instrWord[0]) ? BASE_SRC2 : BASE_SRC;
      instrValid = 1'b1;
      k = (baseSel != BASE_SRC || f == FMT_SRC) ? instrWord[11:8] : instrWord[7:4];
      r = regs[k];
      o2 = (f == FMT_MAC) ? regs[instrWord[11:8]] : 32'h0;
      st = (s == SIZE_LONG) ? STEP_LONG : (s == SIZE_WORD) ? STEP_WORD : STEP_BYTE;
      pcb = (s == SIZE_LONG) ? (pcValue & PC_LONG_MASK) : pcValue;
      ea = 32'h0;
      op = 32'h0;
      up = r;
      case (m)
         MODE_REG_DIRECT: op = r;
         MODE_INDIRECT:   ea = r;
         MODE_POST_INC:   begin ea = r; up = r + st; end
         MODE_PRE_DEC:    begin ea = r - st; up = ea; end
         MODE_PC_DISP:    ea = pcb + {24'h0, instrWord[7:0]} * st;
         MODE_BRANCH8:    ea = pcValue + {{23{instrWord[7]}}, instrWord[7:0], 1'b0};
         MODE_BRANCH12:   ea = pcValue + {{19{instrWord[11]}}, instrWord[11:0], 1'b0};
         MODE_PC_REG:     ea = pcValue + r;
         MODE_IMM_ZERO:   op = {24'h0, instrWord[7:0]};
         MODE_IMM_SIGN:   op = {{24{instrWord[7]}}, instrWord[7:0]};
         default:         op = {22'h0, instrWord[7:0], 2'h0};
      endcase
      @(posedge core_clk);
      #1;
      chk(resultValid, 32'h1);
      chk(effAddr, ea);
      chk(operand, op);
      chk({opcode, srcIndex, destIndex, src2Index},
          {instrWord[15:12], (f == FMT_SRC) ? instrWord[11:8] : instrWord[7:4],
           instrWord[11:8], instrWord[11:8]});
      chk({srcValid, destValid, src2Valid},
          {f == FMT_SRC || f == FMT_NM || f == FMT_MAC,
           f == FMT_DEST || f == FMT_NM || f == FMT_NI, f == FMT_MAC});
      chk(operand2, o2);
      chk({updValid, addrValid, targetValid}, {m == MODE_POST_INC || m == MODE_PRE_DEC,
          m >= MODE_INDIRECT && m <= MODE_PC_DISP, m >= MODE_BRANCH8 && m <= MODE_PC_REG});
      if (m == MODE_POST_INC || m == MODE_PRE_DEC) chk({updIndex, updValue}, {k, up});
      regs[k] = up;
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Clock at 10 MHz.
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Watchdog sized well above the roughly 560 cycles the run needs.
   initial begin
      #(3000 * 100);
      num_errors++;
      stop_test();
   end

   // Corner sweep over every mode and size on wrap-prone values, then a random run.
   initial begin
      {reset_n, instrValid, regWrEn, regWrIndex, regWrData, instrWord, pcValue} = '0;
      instrFormat = FMT_ZERO;
      addrMode = MODE_REG_DIRECT;
      accessSize = SIZE_BYTE;
      baseSel = BASE_SRC;
      foreach (regs[i]) regs[i] = 32'h0;
      repeat (3) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      for (int i = 0; i < 16; i++) wr(4'(i), i[0] ? 32'hFFFF_FFFF : 32'h0000_0000);
      for (int m = 0; m < 11; m++)
         for (int s = 0; s < 3; s++) issue(eau_mode_e'(m), eau_size_e'(s), FMT_SRC);
      $display("Corner sweep finished");
      for (int i = 0; i < 400; i++) begin
         if (rnd() % 4 == 0) wr(4'(rnd()), rnd());
         issue(eau_mode_e'(rnd() % 11), eau_size_e'(rnd() % 3), fmtList[rnd() % 7]);
      end
      wr(4'h0, 32'h0);
      $display("Random run finished");
      stop_test();
   end
endmodule
`default_nettype wire
